// [wig_params.svh]
`ifndef WIG_PARAMS_SVH
`define WIG_PARAMS_SVH
// register byte addresses
`define WIG_OFF_WAKE      12'h064
`define WIG_OFF_PKT       12'h068
`define WIG_OFF_IRQ_STAT  12'h0C0
`define WIG_OFF_IRQ_EN    12'h0C4
`define WIG_OFF_IRQ_CLR   12'h0C8
`define WIG_OFF_CTRL      12'h0CC
// field positions
`define WIG_POL_LSB       16
`define WIG_LINKUP_BIT    31
`define WIG_ALWAYS_BIT    31
`define WIG_SRC_LSB       11
`define WIG_SEVEN         7
// writable masks
`define WIG_WAKE_MASK     32'h87FF07FF
`define WIG_PKT_MASK      32'h800FFFFF
// reset values
`define WIG_RST_ZERO      32'h00000000
`endif

// [wig_pkg.sv]
package wig_pkg;
    // wake-enable image source, gray coded
    typedef enum logic [1:0] {
        WIG_IMG_NONE   = 2'b00,
        WIG_IMG_LOADED = 2'b01
    } wig_img_e;
    // all block state
    typedef struct packed {
        logic [10:0] wake_allow;
        logic [10:0] active_level;
        logic        link_up_wake_enable;
        logic [19:0] event_allow;
        logic        packet_always_on;
        logic [10:0] eeprom_image;
        wig_img_e    img;
        logic [2:0]  irq_stat;
        logic [2:0]  irq_en;
        logic        protect;
        logic [31:0] prdata;
        logic        pready;
        logic        pslverr;
        logic [10:0] wake_hit;
        logic        wake;
        logic        link_wake;
        logic        packet_req;
        logic        irq;
    } wig_state_s;
endpackage

// [wig_gate.sv]
`timescale 1ns/100ps
`include "wig_params.svh"
// Operation
// - wake enable bit gates each pin's wake
// - polarity bit picks active pin level
// - non-gpio pins never wake the device
// - link-up enable lets pin seven wake
// - wake enables default from eeprom image
// - usb or lite reset restores image
// - protection shields wake field on usb or lite reset
// - always-on sends packet every interval
// - otherwise packet only on enabled event
// - bits 19..16 gate mac and fifo events
// - bits 15..11 gate phy and tx events
// - bits 10..0 gate pin events
// - one enables event, zero blocks it
// - control and polarity reset to zero
module wig_gate #(
    parameter int PINS    = 11,  // general purpose pins
    parameter int SOURCES = 9    // internal event sources
) (
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    input  wire logic [3:0]  pstrb,
    output logic [31:0]      prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic [10:0] pin_level,         // synchronous pin levels
    input  wire logic [10:0] pin_is_gpio,       // pin muxed as gpio
    input  wire logic        suspended,         // suspend zero or three
    input  wire logic        usb_reset,         // usb bus reset pulse
    input  wire logic        lite_reset,        // soft reset pulse
    input  wire logic        eeprom_load,       // image load strobe
    input  wire logic [10:0] eeprom_wake,       // loaded wake bits
    input  wire logic [8:0]  src_event,         // mac/fifo/phy/tx events
    input  wire logic        poll_interval,     // endpoint interval tick
    output logic [10:0]      wake_hit,          // per pin wake request
    output logic             wake,              // any per pin wake request
    output logic             link_wake,         // link-up wake via pin seven
    output logic             packet_req,        // send interrupt packet
    output logic             irq
);

    // elaboration check: layout is fixed to 11 pins, 9 sources
    if (PINS != 11 || SOURCES != 9) begin : g_bad
        $error("wig_gate supports 11 pins and 9 sources only");
    end

    wig_pkg::wig_state_s s_q;  // registered state
    wig_pkg::wig_state_s s_d;  // next state

    // pin asserted at its selected level
    function automatic logic [10:0] level_match(input logic [10:0] lvl, input logic [10:0] pol);
        level_match = ~(lvl ^ pol);
    endfunction

    // word read from a register address
    function automatic logic [31:0] read_word(input wig_pkg::wig_state_s s, input logic [11:0] a);
        read_word = 32'h00000000;  // unmapped and reserved read zero
        if (a == `WIG_OFF_WAKE) begin
            read_word = {s.link_up_wake_enable, 4'h0, s.active_level, 5'h00, s.wake_allow};
        end else if (a == `WIG_OFF_PKT) begin
            read_word = {s.packet_always_on, 11'h000, s.event_allow};
        end else if (a == `WIG_OFF_IRQ_STAT) begin
            read_word = {29'h00000000, s.irq_stat};
        end else if (a == `WIG_OFF_IRQ_EN) begin
            read_word = {29'h00000000, s.irq_en};
        end else if (a == `WIG_OFF_CTRL) begin
            read_word = {30'h00000000, s.img == wig_pkg::WIG_IMG_LOADED, s.protect};
        end
    endfunction

    logic [31:0] wmask;  // byte-lane mask
    logic        wr;     // write takes effect
    logic        rd;     // read access phase
    logic [31:0] wv;     // merged wake word
    logic [31:0] pv;     // merged packet word
    logic [10:0] pin_ev;  // qualified pin events
    logic [19:0] all_ev;  // all event sources
    logic        any_ev;

    // next-state logic
    always_comb begin
        s_d   = s_q;
        wmask = {{8{pstrb[3]}}, {8{pstrb[2]}}, {8{pstrb[1]}}, {8{pstrb[0]}}};
        wr    = psel && penable && pwrite;
        rd    = psel && penable && !pwrite;
        wv    = {s_q.link_up_wake_enable, 4'h0, s_q.active_level, 5'h00, s_q.wake_allow};
        pv    = {s_q.packet_always_on, 11'h000, s_q.event_allow};

        // zero-wait slave: ready in every access phase
        s_d.pready  = psel && !penable;
        s_d.pslverr = 1'b0;
        if (psel && !penable && !pwrite) begin
            s_d.prdata = read_word(s_q, paddr);
        end

        // register writes, reserved bits masked off
        if (wr && paddr == `WIG_OFF_WAKE) begin
            wv = ((wv & ~wmask) | (pwdata & wmask)) & `WIG_WAKE_MASK;
            s_d.wake_allow          = wv[10:0];
            s_d.active_level        = wv[`WIG_POL_LSB +: 11];
            s_d.link_up_wake_enable = wv[`WIG_LINKUP_BIT];
        end else if (wr && paddr == `WIG_OFF_PKT) begin
            pv = ((pv & ~wmask) | (pwdata & wmask)) & `WIG_PKT_MASK;
            s_d.event_allow      = pv[19:0];
            s_d.packet_always_on = pv[`WIG_ALWAYS_BIT];
        end else if (wr && paddr == `WIG_OFF_IRQ_EN && pstrb[0]) begin
            s_d.irq_en = pwdata[2:0];
        end else if (wr && paddr == `WIG_OFF_CTRL && pstrb[0]) begin
            s_d.protect = pwdata[0];
        end

        // eeprom load refreshes the image and the field
        if (eeprom_load) begin
            s_d.eeprom_image = eeprom_wake;
            s_d.img          = wig_pkg::WIG_IMG_LOADED;
            s_d.wake_allow   = eeprom_wake;
        end else if ((usb_reset || lite_reset) && !s_q.protect) begin
            // image is zero when no eeprom was ever loaded
            s_d.wake_allow = (s_q.img == wig_pkg::WIG_IMG_LOADED) ? s_q.eeprom_image : 11'h000;
        end

        // pin wake qualification
        pin_ev        = level_match(pin_level, s_q.active_level) & pin_is_gpio;
        s_d.wake_hit  = pin_ev & s_q.wake_allow;
        s_d.wake      = |(pin_ev & s_q.wake_allow);
        s_d.link_wake = s_q.link_up_wake_enable && suspended && pin_ev[`WIG_SEVEN];

        // interrupt packet gating
        all_ev = {src_event, pin_ev};  // sources sit at bits 19..11
        any_ev = |(all_ev & s_q.event_allow);
        s_d.packet_req = poll_interval && (s_q.packet_always_on || any_ev);

        // sticky status: set wins over a same-cycle clear
        if (wr && paddr == `WIG_OFF_IRQ_CLR && pstrb[0]) begin
            s_d.irq_stat = s_q.irq_stat & ~pwdata[2:0];
        end
        s_d.irq_stat = s_d.irq_stat | {any_ev, s_d.link_wake, s_d.wake};
        s_d.irq      = |(s_d.irq_stat & s_d.irq_en);
    end

    // state register; everything resets to zero
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    // outputs straight from flops
    assign prdata     = s_q.prdata;
    assign pready     = s_q.pready;
    assign pslverr    = s_q.pslverr;
    assign wake_hit   = s_q.wake_hit;
    assign wake       = s_q.wake;
    assign link_wake  = s_q.link_wake;
    assign packet_req = s_q.packet_req;
    assign irq        = s_q.irq;

endmodule

// [wig_gate_assertions.sv]
`timescale 1ns/100ps
// pin-level watch on wake, packet and bus timing
module wig_chk (
    input wire logic        pclk,
    input wire logic        presetn,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pready,
    input wire logic        pslverr,
    input wire logic [10:0] pin_is_gpio,
    input wire logic        suspended,
    input wire logic        poll_interval,
    input wire logic [10:0] wake_hit,
    input wire logic        wake,
    input wire logic        link_wake,
    input wire logic        packet_req
);
    // single domain, so one clock and one disable for all
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    chk_pkt_on_poll: assert property (packet_req |-> $past(poll_interval))
        else $error("packet request without interval tick");
    chk_wake_gpio_only: assert property ((wake_hit & ~$past(pin_is_gpio)) == 11'h000)
        else $error("wake from a pin not muxed as gpio");
    chk_wake_any: assert property ((|wake_hit) |-> wake)
        else $error("pin wake not summed into wake");
    chk_link_suspend: assert property (link_wake |-> $past(suspended) && $past(pin_is_gpio[7]))
        else $error("link wake outside suspend or pin seven not gpio");
    chk_ready_access: assert property (pready |-> psel && penable)
        else $error("pready outside access phase");
    chk_ready_one: assert property (psel && !penable |=> pready ##1 !pready)
        else $error("pready not one cycle after setup");
    chk_no_slverr: assert property (!pslverr)
        else $error("pslverr raised");
    chk_quiet_start: assert property ($rose(presetn) |-> !wake && !packet_req && !pready)
        else $error("outputs active at reset release");
endmodule

bind wig_gate wig_chk wig_chk_i (.pclk, .presetn, .psel, .penable, .pready, .pslverr, .pin_is_gpio,
    .suspended, .poll_interval, .wake_hit, .wake, .link_wake, .packet_req);

// [wig_host_model.sv]
`timescale 1ns/100ps
// endpoint poller: ticks one interval on request, flags when packet_req is due
module wig_host_model (
    input  wire logic pclk,
    input  wire logic presetn,
    input  wire logic poll_go,        // bench asks for one interval
    output logic      poll_interval,  // one-cycle interval tick
    output logic      seen            // packet decision valid now
);
    // the decision lands one cycle after the tick
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            poll_interval <= 1'b0;
            seen <= 1'b0;
        end else begin
            poll_interval <= poll_go;
            seen <= poll_interval;
        end
    end
endmodule

// [wig_gate_tb_top.sv]
`timescale 1ns/100ps
module wig_gate_tb_top;
    logic        pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, suspended = 1'b0;
    logic        poll_go = 1'b0, poll_interval, seen, pready, pslverr, wake, link_wake, packet_req, irq;
    logic [2:0]  kick = 3'h0;   // usb reset, lite reset, eeprom load
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h00000000, prdata;
    logic [10:0] pin_level = 11'h000, pin_is_gpio = 11'h000, w, p, wake_hit;
    logic [8:0]  src_event = 9'h000;
    logic [31:0] rd_q[$];       // expected read words
    logic        pk_q[$];       // expected packet decisions
    int          errors = 0, comparisons = 0;
    always #10 pclk = ~pclk;
    wig_gate wig_gate_i (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb(4'hF), .prdata,
        .pready, .pslverr, .pin_level, .pin_is_gpio, .suspended, .usb_reset(kick[0]), .lite_reset(kick[1]),
        .eeprom_load(kick[2]), .eeprom_wake(11'h155), .src_event, .poll_interval, .wake_hit, .wake,
        .link_wake, .packet_req, .irq);
    wig_host_model wig_host_model_i (.pclk, .presetn, .poll_go, .poll_interval, .seen);
    task automatic report_and_stop;
        $display("errors %0d comparisons %0d", errors, comparisons);
        if (errors == 0 && comparisons > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask
    task automatic chk(input string what, input logic [31:0] e, input logic [31:0] s);
        comparisons++;
        if (s !== e) begin
            errors++;
            $display("MISMATCH %s expected %h seen %h", what, e, s);
        end
    endtask
    // one apb transfer, held until pready is sampled high
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        int n = 0;
        @(posedge pclk);
        {psel, pwrite, paddr, pwdata} <= {1'b1, wr, a, d};
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1 && ++n < 20);
        {psel, penable} <= 2'b00;
        if (n >= 20) begin
            errors++;  // a wait that runs out is a mismatch
            report_and_stop();
        end
    endtask
    task automatic rd(input logic [11:0] a, input logic [31:0] e); rd_q.push_back(e); apb(1'b0, a, 0); endtask
    task automatic wr(input logic [11:0] a, input logic [31:0] d); apb(1'b1, a, d); endtask
    task automatic pulse(input logic [2:0] m); @(posedge pclk) kick <= m; @(posedge pclk) kick <= 3'h0; endtask
    // one interval; expected packet decision noted first
    task automatic poll(input logic e);
        pk_q.push_back(e);
        @(posedge pclk) poll_go <= 1'b1;
        @(posedge pclk) poll_go <= 1'b0;
        repeat (3) @(posedge pclk);
    endtask
    // watcher: takes the oldest note whenever a result shows
    always @(posedge pclk) begin
        if (pready === 1'b1 && pwrite === 1'b0 && rd_q.size() > 0) chk("prdata", rd_q.pop_front(), prdata);
        if (seen === 1'b1 && pk_q.size() > 0) chk("packet_req", 32'(pk_q.pop_front()), 32'(packet_req));
    end
    initial begin
        void'($urandom(32'h07F63CC2));
        repeat (12) @(posedge pclk);
        presetn <= 1'b1;
        rd(12'h064, 32'h0);
        rd(12'h068, 32'h0);
        wr(12'h068, 32'hFFFFFFFF);
        rd(12'h068, 32'h800FFFFF);
        wr(12'h064, 32'hFFFFFFFF);
        rd(12'h064, 32'h87FF07FF);
        rd(12'h100, 32'h0);
        wr(12'h064, 32'h0);
        // each source alone, then every source but it
        for (int k = 0; k < 9; k++) begin
            wr(12'h068, 32'h1 << (11 + k));
            src_event <= 9'h1 << k;
            poll(1'b1);
            src_event <= ~(9'h1 << k);
            poll(1'b0);
        end
        src_event <= 9'h000;
        pin_is_gpio <= 11'h7FF;
        for (int i = 0; i < 11; i++) begin
            {p, w} = {11'($urandom), 11'($urandom)};
            pin_level <= w;
            wr(12'h064, {5'h00, p, 16'h0000});
            wr(12'h068, 32'h1 << i);
            poll(w[i] == p[i]);
        end
        // random wake mix, link-up armed in suspend
        {p, w} = {11'($urandom), 11'($urandom)};
        {suspended, pin_is_gpio} <= {1'b1, 11'($urandom) | 11'h080};
        wr(12'h064, {1'b1, 4'h0, p, 5'h00, w});
        pin_level <= 11'($urandom);
        repeat (2) @(posedge pclk);
        chk("wake_hit", 32'(w & pin_is_gpio & ~(pin_level ^ p)), 32'(wake_hit));
        chk("wake", 32'(|(w & pin_is_gpio & ~(pin_level ^ p))), 32'(wake));
        chk("link_wake", 32'(pin_is_gpio[7] & ~(pin_level[7] ^ p[7])), 32'(link_wake));
        {suspended, pin_is_gpio} <= 12'h000;
        wr(12'h068, 32'h80000000);
        poll(1'b1);
        wr(12'h068, 32'h0);
        poll(1'b0);
        // raise, mask and clear the pin wake interrupt
        wr(12'h064, 32'h1);
        wr(12'h0C8, 32'h7);
        wr(12'h0C4, 32'h1);
        {pin_level, pin_is_gpio} <= {11'h000, 11'h001};
        @(posedge pclk) pin_is_gpio <= 11'h000;
        rd(12'h0C0, 32'h1);
        chk("irq", 32'h1, 32'(irq));
        wr(12'h0C4, 32'h0);
        @(posedge pclk) chk("irq", 32'h0, 32'(irq));
        wr(12'h0C8, 32'h1);
        rd(12'h0C0, 32'h0);
        // resets against no image, a loaded image, and protection
        wr(12'h064, 32'h7FF);
        pulse(3'h1);
        rd(12'h064, 32'h0);
        pulse(3'h4);
        rd(12'h064, 32'h155);
        wr(12'h064, 32'h7FF);
        pulse(3'h2);
        rd(12'h064, 32'h155);
        wr(12'h0CC, 32'h1);
        wr(12'h064, 32'h7FF);
        pulse(3'h1);
        rd(12'h064, 32'h7FF);
        report_and_stop();
    end
endmodule
